// ===== design/reset_and_watchdog_unit.sv
// reset latch, reset delay timer, watchdog and status flags with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "reset_watchdog_consts.svh"

module reset_and_watchdog_unit #(
   parameter int RESET_DELAY_CYCLES = `RESET_DELAY_TIME_MS * `MCLK_PER_MS,
   parameter int WATCHDOG_BASE_CYCLES = `WATCHDOG_PERIOD_MS * `MCLK_PER_MS,
   parameter int CNT_W = `DELAY_CNT_W,
   parameter int ADDR_W = 12
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic master_clear_pin,
   input wire logic watchdog_enable_fuse,
   input wire logic clear_watchdog_instr,
   input wire logic sleep_instr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chip_reset,
   output logic sleep_active,
   output logic watchdog_reset,
   output logic [5:0] option_value,
   output logic [7:0] port_direction,
   output logic [7:0] program_counter_low,
   output logic [7:0] indirect_pointer
);
   // pin synchronisers, first stage read only by the second
   logic [1:0] pin_sync_reg;
   logic [1:0] pin_sync_next;
   logic [1:0] fuse_sync_reg;
   logic [1:0] fuse_sync_next;
   logic pin_high;
   logic fuse_on;

   reset_watchdog_pkg::seq_state_e state_reg;
   reset_watchdog_pkg::seq_state_e state_next;
   logic timeout_flag_reg;
   logic timeout_flag_next;
   logic powerdown_flag_reg;
   logic powerdown_flag_next;
   logic chip_reset_reg;
   logic chip_reset_next;
   logic sleep_active_reg;
   logic sleep_active_next;
   logic watchdog_reset_reg;
   logic watchdog_reset_next;

   logic delay_clear;
   logic delay_run;
   logic delay_done;
   logic dog_run;
   logic dog_clear;
   logic dog_base_done;
   logic dog_timeout;
   logic clear_dog_take;
   logic sleep_take;
   logic in_reset;

   logic [`PRESC_W-1:0] presc_reg;
   logic [`PRESC_W-1:0] presc_next;
   logic [`PRESC_W-1:0] presc_mask;
   logic [2:0] presc_ratio;
   logic prescaler_assign;
   logic presc_match;

   logic [7:0] pc_low_reg;
   logic [7:0] pc_low_next;
   logic [2:0] status_high_reg;
   logic [2:0] status_high_next;
   logic [2:0] status_low_reg;
   logic [2:0] status_low_next;
   logic [7:0] pointer_reg;
   logic [7:0] pointer_next;
   logic [5:0] option_reg;
   logic [5:0] option_next;
   logic [7:0] direction_reg;
   logic [7:0] direction_next;
   logic [7:0] gpfile_reg;
   logic [7:0] gpfile_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [`IDX_W-1:0] idx;
   logic setup_phase;
   logic write_take;
   logic addr_hit;
   logic [31:0] read_word;
   logic [7:0] status_word;

   always_comb begin
      pin_sync_next = {pin_sync_reg[0], master_clear_pin};
      fuse_sync_next = {fuse_sync_reg[0], watchdog_enable_fuse};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_sync_reg <= 2'h0;
         fuse_sync_reg <= 2'h0;
      end else begin
         pin_sync_reg <= pin_sync_next;
         fuse_sync_reg <= fuse_sync_next;
      end
   end

   assign pin_high = pin_sync_reg[1];
   assign fuse_on = fuse_sync_reg[1];

   // instructions only count while the core runs and the pin is high
   assign clear_dog_take = (state_reg == reset_watchdog_pkg::seq_run) && pin_high && clear_watchdog_instr;
   assign sleep_take = (state_reg == reset_watchdog_pkg::seq_run) && pin_high && sleep_instr;
   assign in_reset = (state_reg == reset_watchdog_pkg::seq_hold) || (state_reg == reset_watchdog_pkg::seq_delay);

   // reset delay timer counts mclk cycles while in the delay state
   assign delay_run = (state_reg == reset_watchdog_pkg::seq_delay);
   assign delay_clear = !delay_run;

   period_counter #(
      .WIDTH(CNT_W)
   ) u_delay_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(delay_clear),
      .run(delay_run),
      .last(CNT_W'(RESET_DELAY_CYCLES - 1)),
      .done(delay_done)
   );

   // watchdog keeps counting in sleep; only this time base is assumed running
   assign dog_run = fuse_on && ((state_reg == reset_watchdog_pkg::seq_run) ||
                                (state_reg == reset_watchdog_pkg::seq_sleep));
   // leaving sleep always passes through reset, which holds the count clear
   assign dog_clear = !dog_run || clear_dog_take || sleep_take;

   period_counter #(
      .WIDTH(CNT_W)
   ) u_dog_base (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(dog_clear),
      .run(dog_run),
      .last(CNT_W'(WATCHDOG_BASE_CYCLES - 1)),
      .done(dog_base_done)
   );

   assign prescaler_assign = option_reg[`OPT_ASSIGN_BIT];
   assign presc_ratio = option_reg[`OPT_PS_HI:`OPT_PS_LO];
   assign presc_mask = `PRESC_FULL >> (3'(`PRESC_W) - presc_ratio);
   assign presc_match = !prescaler_assign || (presc_reg == presc_mask);
   // a clear in the pulse cycle still cancels the pending time-out
   assign dog_timeout = dog_base_done && presc_match && !dog_clear;

   always_comb begin
      presc_next = presc_reg;
      if (dog_clear || !prescaler_assign) begin
         presc_next = '0;
      end else if (dog_base_done) begin
         presc_next = presc_match ? '0 : `PRESC_W'(presc_reg + 1'b1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_next;
      end
   end

   // sequencer: the pin outranks a time-out, an instruction in the pulse cycle cancels a time-out
   always_comb begin
      state_next = state_reg;
      timeout_flag_next = timeout_flag_reg;
      powerdown_flag_next = powerdown_flag_reg;
      case (state_reg)
         reset_watchdog_pkg::seq_hold: begin
            if (pin_high) begin
               state_next = reset_watchdog_pkg::seq_delay;
            end
         end
         reset_watchdog_pkg::seq_delay: begin
            if (!pin_high) begin
               state_next = reset_watchdog_pkg::seq_hold;
            end else if (delay_done) begin
               state_next = reset_watchdog_pkg::seq_run;
            end
         end
         reset_watchdog_pkg::seq_run: begin
            if (!pin_high) begin
               state_next = reset_watchdog_pkg::seq_hold;
            end else if (dog_timeout) begin
               state_next = reset_watchdog_pkg::seq_delay;
               timeout_flag_next = 1'b0;
            end else if (sleep_take) begin
               state_next = reset_watchdog_pkg::seq_sleep;
               timeout_flag_next = 1'b1;
               powerdown_flag_next = 1'b0;
            end else if (clear_dog_take) begin
               timeout_flag_next = 1'b1;
               powerdown_flag_next = 1'b1;
            end
         end
         reset_watchdog_pkg::seq_sleep: begin
            if (!pin_high) begin
               state_next = reset_watchdog_pkg::seq_hold;
               timeout_flag_next = 1'b1;
               powerdown_flag_next = 1'b0;
            end else if (dog_timeout) begin
               state_next = reset_watchdog_pkg::seq_delay;
               timeout_flag_next = 1'b0;
            end
         end
         default: begin
            state_next = reset_watchdog_pkg::seq_hold;
         end
      endcase
      chip_reset_next = (state_next == reset_watchdog_pkg::seq_hold) ||
                        (state_next == reset_watchdog_pkg::seq_delay);
      sleep_active_next = (state_next == reset_watchdog_pkg::seq_sleep);
      watchdog_reset_next = dog_timeout;
   end

   // rst_n is the power-up detector; nothing resets on a falling supply
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= reset_watchdog_pkg::seq_hold;
         timeout_flag_reg <= 1'b1;
         powerdown_flag_reg <= 1'b1;
         chip_reset_reg <= 1'b1;
         sleep_active_reg <= 1'b0;
         watchdog_reset_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timeout_flag_reg <= timeout_flag_next;
         powerdown_flag_reg <= powerdown_flag_next;
         chip_reset_reg <= chip_reset_next;
         sleep_active_reg <= sleep_active_next;
         watchdog_reset_reg <= watchdog_reset_next;
      end
   end

   // apb slave: no wait states, read word captured in the setup cycle
   assign idx = paddr[`IDX_W+1:2];
   assign setup_phase = psel && !penable;
   assign write_take = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign status_word = {status_high_reg, timeout_flag_reg, powerdown_flag_reg, status_low_reg};

   always_comb begin
      addr_hit = 1'b1;
      read_word = 32'h0;
      case (idx)
         `REG_IDX_PC_LOW: read_word = {24'h0, pc_low_reg};
         `REG_IDX_STATUS: read_word = {24'h0, status_word};
         `REG_IDX_POINTER: read_word = {24'h0, pointer_reg};
         `REG_IDX_OPTION: read_word = 32'h0;
         `REG_IDX_DIRECTION: read_word = {24'h0, direction_reg};
         `REG_IDX_GPFILE: read_word = {24'h0, gpfile_reg};
         default: addr_hit = 1'b0;
      endcase
   end

   always_comb begin
      pready_next = setup_phase;
      pslverr_next = setup_phase && !addr_hit;
      prdata_next = (setup_phase && !pwrite) ? read_word : 32'h0;
      pc_low_next = pc_low_reg;
      status_high_next = status_high_reg;
      status_low_next = status_low_reg;
      pointer_next = pointer_reg;
      option_next = option_reg;
      direction_next = direction_reg;
      gpfile_next = gpfile_reg;
      if (write_take) begin
         case (idx)
            `REG_IDX_PC_LOW: pc_low_next = pwdata[7:0];
            `REG_IDX_STATUS: begin
               status_high_next = pwdata[7:5];
               status_low_next = pwdata[2:0];
            end
            `REG_IDX_POINTER: pointer_next = pwdata[7:0];
            `REG_IDX_OPTION: option_next = pwdata[5:0];
            `REG_IDX_DIRECTION: direction_next = pwdata[7:0];
            `REG_IDX_GPFILE: gpfile_next = pwdata[7:0];
            default: ;
         endcase
      end
      // reset load wins over software for as long as the latch is set
      if (in_reset) begin
         pc_low_next = `PC_LOW_RESET;
         direction_next = `DIRECTION_RESET;
         option_next = `OPTION_RESET;
         status_high_next = `STATUS_HIGH_RESET;
         pointer_next[`POINTER_TOP_BIT] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pc_low_reg <= `PC_LOW_RESET;
         status_high_reg <= `STATUS_HIGH_RESET;
         status_low_reg <= `STATUS_LOW_POWERUP;
         pointer_reg <= {1'b1, `POINTER_LOW_POWERUP};
         option_reg <= `OPTION_RESET;
         direction_reg <= `DIRECTION_RESET;
         gpfile_reg <= `GPFILE_POWERUP;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         pc_low_reg <= pc_low_next;
         status_high_reg <= status_high_next;
         status_low_reg <= status_low_next;
         pointer_reg <= pointer_next;
         option_reg <= option_next;
         direction_reg <= direction_next;
         gpfile_reg <= gpfile_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign chip_reset = chip_reset_reg;
   assign sleep_active = sleep_active_reg;
   assign watchdog_reset = watchdog_reset_reg;
   assign option_value = option_reg;
   assign port_direction = direction_reg;
   assign program_counter_low = pc_low_reg;
   assign indirect_pointer = pointer_reg;
endmodule
`default_nettype wire

// ===== design/reset_watchdog_consts.svh
// constants for the reset and watchdog unit
`ifndef RESET_WATCHDOG_CONSTS_SVH
`define RESET_WATCHDOG_CONSTS_SVH

// timing
`define MCLK_HZ 20000000
`define MCLK_PER_MS 20000
`define RESET_DELAY_TIME_MS 18
`define WATCHDOG_PERIOD_MS 18
`define DELAY_CNT_W 19

// watchdog prescaler, up to 1:128
`define PRESC_W 7
`define PRESC_FULL 7'h7f

// register word indices, byte address is four times the index
`define IDX_W 10
`define REG_IDX_PC_LOW 10'h002
`define REG_IDX_STATUS 10'h003
`define REG_IDX_POINTER 10'h004
`define REG_IDX_OPTION 10'h008
`define REG_IDX_DIRECTION 10'h009
`define REG_IDX_GPFILE 10'h00a

// field positions
`define STATUS_TO_BIT 4
`define STATUS_POWERDOWN_BIT 3
`define OPT_ASSIGN_BIT 3
`define OPT_PS_HI 2
`define OPT_PS_LO 0
`define POINTER_TOP_BIT 7

// reset values
`define PC_LOW_RESET 8'hff
`define DIRECTION_RESET 8'hff
`define OPTION_RESET 6'h3f
`define STATUS_HIGH_RESET 3'h0
`define STATUS_LOW_POWERUP 3'h0
`define POINTER_LOW_POWERUP 7'h00
`define GPFILE_POWERUP 8'h00

`endif

// ===== design/reset_watchdog_pkg.sv
// types for the reset and watchdog unit
package reset_watchdog_pkg;
   typedef enum logic [1:0] {
      seq_hold = 2'b00,
      seq_delay = 2'b01,
      seq_run = 2'b10,
      seq_sleep = 2'b11
   } seq_state_e;
endpackage

// ===== design/period_counter.sv
// free counter giving a one-cycle pulse each time it passes its last value
`timescale 1ns/1ps
`default_nettype none
module period_counter #(
   parameter int WIDTH = 19
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic run,
   input wire logic [WIDTH-1:0] last,
   output logic done
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic done_reg;
   logic done_next;

   always_comb begin
      count_next = count_reg;
      done_next = 1'b0;
      if (clear || !run) begin
         count_next = '0;
      end else if (count_reg == last) begin
         count_next = '0;
         done_next = 1'b1;
      end else begin
         count_next = WIDTH'(count_reg + 1'b1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         count_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule
`default_nettype wire

// ===== tb/reset_watchdog_checker_asserts.sv
// port assertions for the reset and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_checker #(
   parameter int RESET_DELAY_CYCLES = 20,
   parameter int WATCHDOG_BASE_CYCLES = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic master_clear_pin,
   input wire logic watchdog_enable_fuse,
   input wire logic clear_watchdog_instr,
   input wire logic sleep_instr,
   input wire logic chip_reset,
   input wire logic sleep_active,
   input wire logic watchdog_reset,
   input wire logic [5:0] option_value,
   input wire logic [7:0] port_direction,
   input wire logic [7:0] program_counter_low,
   input wire logic [7:0] indirect_pointer
);
   int hi_reg, hi_next, fl_reg, fl_next, qt_reg, qt_next;
   // instructions in sleep are ignored, so they must not restart the quiet count
   always_comb begin
      hi_next = master_clear_pin ? hi_reg + 1 : 0;
      fl_next = watchdog_enable_fuse ? 0 : fl_reg + 1;
      qt_next = qt_reg + 1;
      if (chip_reset || ((clear_watchdog_instr || sleep_instr) && !sleep_active)) begin
         qt_next = 0;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hi_reg <= 0;
         fl_reg <= 0;
         qt_reg <= 0;
      end else begin
         hi_reg <= hi_next;
         fl_reg <= fl_next;
         qt_reg <= qt_next;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_pin_hold;
      !master_clear_pin [*5] |-> chip_reset;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("latch released with pin low");
   property p_delay_min;
      $fell(chip_reset) |-> hi_reg >= RESET_DELAY_CYCLES + 2;
   endproperty
   a_delay_min: assert property (p_delay_min) else $error("reset ended too early");
   property p_wd_full;
      watchdog_reset |-> chip_reset;
   endproperty
   a_wd_full: assert property (p_wd_full) else $error("time-out without chip reset");
   property p_wd_pulse;
      watchdog_reset |=> !watchdog_reset;
   endproperty
   a_wd_pulse: assert property (p_wd_pulse) else $error("time-out pulse too long");
   property p_fuse_off;
      fl_reg >= 5 |-> !watchdog_reset;
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("time-out with fuse off");
   property p_wd_period;
      watchdog_reset |-> qt_reg >= WATCHDOG_BASE_CYCLES;
   endproperty
   a_wd_period: assert property (p_wd_period) else $error("time-out before base period");
   property p_reload;
      chip_reset [*2] |-> option_value == 6'h3f && port_direction == 8'hff && program_counter_low == 8'hff
         && indirect_pointer[7];
   endproperty
   a_reload: assert property (p_reload) else $error("reset values not loaded");
   property p_sleep_entry;
      master_clear_pin [*4] ##0 (sleep_instr && !chip_reset && !sleep_active) |=> sleep_active;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
   property p_no_sleep_in_reset;
      chip_reset |-> !sleep_active;
   endproperty
   a_no_sleep_in_reset: assert property (p_no_sleep_in_reset) else $error("sleep during reset");
   c_wd_reset: cover property (watchdog_reset);
   c_wake: cover property (sleep_active ##1 !sleep_active);
   c_release: cover property ($fell(chip_reset));
endmodule
bind reset_and_watchdog_unit reset_watchdog_checker #(
   .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES),
   .WATCHDOG_BASE_CYCLES(WATCHDOG_BASE_CYCLES)
) chk_i (
   .mclk(mclk), .rst_n(rst_n), .master_clear_pin(master_clear_pin),
   .watchdog_enable_fuse(watchdog_enable_fuse), .clear_watchdog_instr(clear_watchdog_instr),
   .sleep_instr(sleep_instr), .chip_reset(chip_reset), .sleep_active(sleep_active),
   .watchdog_reset(watchdog_reset), .option_value(option_value), .port_direction(port_direction),
   .program_counter_low(program_counter_low), .indirect_pointer(indirect_pointer)
);
`default_nettype wire

// ===== tb/master_clear_pin_source.sv
// external master-clear driver model
`timescale 1ns/1ps
`default_nettype none
module pin_driver_model (
   input wire logic mclk,
   input wire logic hold_low,
   output logic master_clear_pin
);
   // pulled up off chip, so a released pin reads high
   always_ff @(posedge mclk) begin
      master_clear_pin <= !hold_low;
   end
endmodule
`default_nettype wire

// ===== tb/reset_and_watchdog_unit_tb.sv
// testbench for the reset and watchdog unit
`timescale 1ns/1ps
`default_nettype none
`include "reset_watchdog_consts.svh"
module reset_and_watchdog_unit_tb;
   localparam int DLY = 20;
   localparam int WDB = 16;
   logic mclk = 0, rst_n = 0, hold_low = 1, fuse = 1, clr = 0, slp = 0;
   logic psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pin, chip_reset, sleep_active, wd_rst;
   logic [5:0] opt;
   logic [7:0] dir;
   int mismatches = 0, tests_run = 0, n;
   always #25 mclk = ~mclk;
   pin_driver_model drv (.mclk(mclk), .hold_low(hold_low), .master_clear_pin(pin));
   reset_and_watchdog_unit #(.RESET_DELAY_CYCLES(DLY), .WATCHDOG_BASE_CYCLES(WDB)) dut (
      .mclk(mclk), .rst_n(rst_n), .master_clear_pin(pin), .watchdog_enable_fuse(fuse),
      .clear_watchdog_instr(clr), .sleep_instr(slp), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_reset(chip_reset), .sleep_active(sleep_active), .watchdog_reset(wd_rst), .option_value(opt),
      .port_direction(dir), .program_counter_low(), .indirect_pointer()
   );
   task automatic summarize;
      $display("mismatches %0d of %0d checks", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      tests_run++;
      if (v < lo || v > hi) begin
         $display("wrong value at %0t: got %h expected %h", $time, v, lo);
         mismatches++;
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge mclk);
         if (pready) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         mismatches++;
         summarize();
      end
      @(posedge mclk);
   endtask
   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wait_wd(input int hi, output int c);
      c = 0;
      while (c <= hi && wd_rst !== 1'b1) begin
         @(posedge mclk);
         c++;
      end
   endtask
   task automatic wait_rel(output int c);
      c = 0;
      while (chip_reset !== 1'b0 && c < 200) begin
         @(posedge mclk);
         c++;
      end
      if (c == 200) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic clr_wd;
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
   endtask
   task automatic go_sleep;
      slp <= 1'b1;
      @(posedge mclk);
      slp <= 1'b0;
      @(posedge mclk);
      chk(32'(sleep_active), 32'h1);
   endtask
   task automatic pin_pulse;
      hold_low <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(32'(chip_reset), 32'h1);
      hold_low <= 1'b0;
      wait_rel(n);
      rng(n, DLY, DLY + 8);
   endtask
   task automatic t_powerup;
      repeat (30) @(posedge mclk);
      chk(32'(chip_reset), 32'h1);
      rchk(`REG_IDX_STATUS, 32'h18);
      rchk(`REG_IDX_PC_LOW, 32'hff);
      rchk(`REG_IDX_POINTER, 32'h80);
      rchk(`REG_IDX_OPTION, 32'h0);
      apb(1'b0, 10'h00f, 32'h0);
      chk(32'(err), 32'h1);
      hold_low <= 1'b0;
      wait_rel(n);
      rng(n, DLY, DLY + 8);
   endtask
   task automatic t_wd_run;
      apb(1'b1, `REG_IDX_OPTION, 32'h09);
      chk(32'(opt), 32'h09);
      apb(1'b1, `REG_IDX_DIRECTION, 32'h00);
      apb(1'b1, `REG_IDX_GPFILE, 32'h5a);
      for (int i = 0; i < 4; i++) begin
         clr_wd();
         wait_wd(WDB + 12, n);
         rng(n, WDB + 13, WDB + 13);
      end
      clr_wd();
      wait_wd(2 * WDB + 8, n);
      rng(n, 2 * WDB, 2 * WDB + 8);
      wait_rel(n);
      rng(n, DLY - 2, DLY + 8);
      chk(32'(opt), 32'h3f);
      chk(32'(dir), 32'hff);
      rchk(`REG_IDX_STATUS, 32'h08);
      rchk(`REG_IDX_GPFILE, 32'h5a);
      clr_wd();
      rchk(`REG_IDX_STATUS, 32'h18);
   endtask
   task automatic t_sleep_wd;
      apb(1'b1, `REG_IDX_OPTION, 32'h00);
      go_sleep();
      wait_wd(WDB + 8, n);
      rng(n, WDB - 1, WDB + 8);
      wait_rel(n);
      rchk(`REG_IDX_STATUS, 32'h00);
   endtask
   task automatic t_master_clear_pin_run;
      pin_pulse();
      rchk(`REG_IDX_STATUS, 32'h00);
      rchk(`REG_IDX_GPFILE, 32'h5a);
   endtask
   task automatic t_fuse_sleep;
      fuse <= 1'b0;
      repeat (4) @(posedge mclk);
      apb(1'b1, `REG_IDX_OPTION, 32'h00);
      go_sleep();
      wait_wd(3 * WDB, n);
      rng(n, 3 * WDB + 1, 3 * WDB + 1);
      rchk(`REG_IDX_STATUS, 32'h10);
      pin_pulse();
      rchk(`REG_IDX_STATUS, 32'h10);
      fuse <= 1'b1;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_powerup();
      t_wd_run();
      t_sleep_wd();
      t_master_clear_pin_run();
      t_fuse_sleep();
      summarize();
   end
endmodule
`default_nettype wire
